// ---- pkg/tx_aux_pkg.sv ----
// Constants shared by the auxiliary transmit slot routing block and its buffer.
// Assumes a byte-wide register port addressed by the documented register addresses.
//
// Contract
// RULE1: Channel 5 source: 0 high-Z, 1 loopback input 1, 2 echo ref 1, 3 reserved.
// RULE2: Channel 6 source: 0 high-Z, 1 loopback input 2, 2 echo ref 2, 3 reserved.
// RULE3: Channel 5 slot 0-31 is TDM slot; split formats use left 0-15, right 16-31.
// RULE4: Channel 6 slot uses the same mapping as channel 5.
// RULE5: Channel 5 register at 0x22, reset 0x04: tri-stated, slot 4.
// RULE6: Channel 6 register at 0x23, reset 0x05: tri-stated, slot 5.
// RULE7: Bit 7 of both registers is reserved read-only; software writes it zero.
// RULE8: Reserved source value 3 behaves as tri-state; nothing is driven.

package tx_aux_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] TX_CH5_ROUTING_ADDR  = 8'h22;
  localparam logic [7:0] TX_CH6_ROUTING_ADDR  = 8'h23;
  localparam logic [7:0] TX_CH5_ROUTING_RESET = 8'h04;
  localparam logic [7:0] TX_CH6_ROUTING_RESET = 8'h05;
  localparam logic [7:0] UNMAPPED_READ        = 8'h00;

  // ********************************************************************
  // Field layout
  // ********************************************************************
  localparam int RESERVED_BIT = 7;
  localparam int SOURCE_MSB   = 6;
  localparam int SOURCE_LSB   = 5;
  localparam int SLOT_MSB     = 4;
  localparam int SLOT_LSB     = 0;

  // ********************************************************************
  // Source selections and slot geometry
  // ********************************************************************
  typedef enum logic [1:0] {
    SRC_TRISTATE = 2'b00,
    SRC_LOOPBACK = 2'b01,
    SRC_ECHO     = 2'b10,
    SRC_RESERVED = 2'b11
  } source_type;

  localparam logic [4:0] HALF_FRAME_SLOTS = 5'h10;
  localparam int         WORD_WIDTH       = 32;
  localparam int         SLOT_WIDTH       = 5;
  localparam int         ENTRY_WIDTH      = WORD_WIDTH + SLOT_WIDTH + 1;
  localparam int         BUFFER_DEPTH     = 2;

endpackage : tx_aux_pkg

// ---- tb/slot_sink.sv ----
// Partner model of the sink that drains placed slot words.
// Assumes one clock; the bench raises stall off the rising edge to hold words back.
`timescale 1ns/1ps
`default_nettype none

module slot_sink
  import tx_aux_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  stall,
  input  wire logic                  out_valid,
  output logic                       out_ready,
  input  wire logic [WORD_WIDTH-1:0] out_word,
  input  wire logic [SLOT_WIDTH-1:0] out_slot,
  input  wire logic                  out_channel6
);
  logic [ENTRY_WIDTH-1:0] got [$];

  // Ready follows stall one edge late, so the block must cope with a slow sink
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      out_ready <= 1'b0;
    else
      out_ready <= !stall;

  // Every accepted word is queued for the bench to compare
  always @(posedge clk)
    if (out_valid && out_ready)
      got.push_back({out_channel6, out_slot, out_word});
endmodule : slot_sink
`default_nettype wire

// ---- tb/test_tx_aux_slot_routing.sv ----
// Self-checking bench for the auxiliary transmit slot routing block.
// Assumes the package and the slot_sink partner are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module test_tx_aux_slot_routing
  import tx_aux_pkg::*;
;
  typedef struct packed {logic [7:0] c5; logic [7:0] c6; logic sp; logic rt;
                         logic [4:0] n; logic drv;} row_type;
  localparam logic [31:0] LB2 = 32'h2222_0002;
  localparam logic [31:0] EC1 = 32'h3333_0003;
  localparam logic [31:0] EC2 = 32'h4444_0004;
  logic                   clk = 1'b0, rstn = 1'b0, stall = 1'b0;
  logic                   reg_write = 1'b0, reg_read = 1'b0, frame_split = 1'b0;
  logic [7:0]             reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic                   slot_valid = 1'b0, slot_right_half = 1'b0, slot_ready;
  logic [4:0]             slot_number = 5'h00, out_slot, eff;
  logic [31:0]            loopback_ch1 = 32'h1111_0001, out_word, w;
  logic                   slot_drive, out_valid, out_ready, out_channel6, hit5;
  logic [ENTRY_WIDTH-1:0] e;
  row_type                r;
  int                     err_count = 0, n_checks = 0;
  // Ordinary cases: both registers, the offered slot, and whether a word appears
  row_type rows [10] = '{'{8'h24, 8'h05, 1'b0, 1'b0, 5'h04, 1'b1},
                        '{8'h44, 8'h5f, 1'b0, 1'b0, 5'h1f, 1'b1},
                        '{8'h50, 8'h05, 1'b1, 1'b1, 5'h00, 1'b1},
                        '{8'h44, 8'h2f, 1'b1, 1'b0, 5'h0f, 1'b1},
                        '{8'h64, 8'h05, 1'b0, 1'b0, 5'h04, 1'b0},
                        '{8'h04, 8'h25, 1'b0, 1'b0, 5'h04, 1'b0},
                        '{8'h27, 8'h27, 1'b0, 1'b0, 5'h07, 1'b1},
                        '{8'h24, 8'h65, 1'b0, 1'b0, 5'h05, 1'b0},
                        '{8'h51, 8'h31, 1'b1, 1'b1, 5'h01, 1'b1},
                        '{8'h50, 8'h05, 1'b1, 1'b0, 5'h10, 1'b0}};

  always #5 clk = ~clk;

  tx_aux_slot_routing DUT (.clk(clk), .rstn(rstn), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_split(frame_split), .slot_valid(slot_valid),
    .slot_ready(slot_ready), .slot_right_half(slot_right_half),
    .slot_number(slot_number), .loopback_ch1(loopback_ch1), .loopback_ch2(LB2),
    .echo_ref_ch1(EC1), .echo_ref_ch2(EC2), .slot_drive(slot_drive),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
    .out_slot(out_slot), .out_channel6(out_channel6));

  slot_sink sink (.clk(clk), .rstn(rstn), .stall(stall), .out_valid(out_valid),
    .out_ready(out_ready), .out_word(out_word), .out_slot(out_slot),
    .out_channel6(out_channel6));

  // ********************************************************************
  // Bus tasks
  // ********************************************************************
  task automatic results();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // Callers keep the reserved top bit at zero
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_write = 1'b1;
    reg_addr  = a;
    reg_wdata = v;
    @(negedge clk);
    reg_write = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_read = 1'b0;
    v = reg_rdata;
  endtask : rd

  // Slot request held until ready; a hang is counted and ends the run
  task automatic offer(input logic sp, input logic rt, input logic [4:0] n);
    int i;
    @(negedge clk);
    frame_split     = sp;
    slot_right_half = rt;
    slot_number     = n;
    slot_valid      = 1'b1;
    // Let the combinational ready settle before looking at it
    #1;
    for (i = 0; i < 20 && slot_ready !== 1'b1; i++)
      @(negedge clk);
    if (slot_ready !== 1'b1)
    begin
      err_count++;
      results();
    end
    @(negedge clk);
    slot_valid = 1'b0;
  endtask : offer

  task automatic wait_got(input int k);
    int i;
    for (i = 0; i < 30 && sink.got.size() < k; i++)
      @(negedge clk);
    if (sink.got.size() < k)
    begin
      err_count++;
      results();
    end
  endtask : wait_got

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial
  begin
    repeat (4) @(negedge clk);
    `CHK({reg_rdata, slot_ready, out_valid, slot_drive}, 11'h004)
    rstn = 1'b1;
    wr(8'h30, 8'h3f);
    rd(TX_CH5_ROUTING_ADDR, d);
    `CHK(d, 8'h04)
    rd(TX_CH6_ROUTING_ADDR, d);
    `CHK(d, 8'h05)
    rd(8'h30, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 10; i++)
    begin
      r = rows[i];
      wr(TX_CH5_ROUTING_ADDR, r.c5);
      rd(TX_CH5_ROUTING_ADDR, d);
      `CHK(d, r.c5)
      wr(TX_CH6_ROUTING_ADDR, r.c6);
      rd(TX_CH6_ROUTING_ADDR, d);
      `CHK(d, r.c6)
      offer(r.sp, r.rt, r.n);
      `CHK(slot_drive, r.drv)
      `CHK(out_valid, r.drv)
      eff  = r.sp ? {r.rt, r.n[3:0]} : r.n;
      hit5 = (r.c5[6:5] == 2'b01 || r.c5[6:5] == 2'b10) && r.c5[4:0] == eff;
      w    = hit5 ? (r.c5[6:5] == 2'b01 ? loopback_ch1 : EC1)
                  : (r.c6[6:5] == 2'b01 ? LB2 : EC2);
      if (r.drv)
      begin
        wait_got(1);
        e = sink.got.pop_front();
        `CHK(e, {!hit5, eff, w})
      end
    end
    // Full buffer refuses a driven slot but still lets a silent slot pass
    wr(TX_CH5_ROUTING_ADDR, 8'h24);
    stall = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      loopback_ch1 = 32'h0000_0a00 + k;
      offer(1'b0, 1'b0, 5'h04);
    end
    offer(1'b0, 1'b0, 5'h09);
    `CHK(slot_drive, 1'b0)
    // Driven slot against a full buffer: held, refused, then taken once drained
    @(negedge clk);
    loopback_ch1 = 32'h0000_0a02;
    slot_number  = 5'h04;
    slot_valid   = 1'b1;
    #1;
    `CHK(slot_ready, 1'b0)
    stall = 1'b0;
    offer(1'b0, 1'b0, 5'h04);
    wait_got(3);
    for (int k = 0; k < 3; k++)
    begin
      e = sink.got.pop_front();
      `CHK(e, {1'b0, 5'h04, 32'h0000_0a00 + k})
    end
    `CHK(out_valid, 1'b0)
    // Reset in mid-run restores both registers
    @(negedge clk);
    rstn = 1'b0;
    #1;
    `CHK({reg_rdata, slot_ready, slot_drive}, 10'h002)
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd(TX_CH5_ROUTING_ADDR, d);
    `CHK(d, 8'h04)
    rd(TX_CH6_ROUTING_ADDR, d);
    `CHK(d, 8'h05)
    results();
  end
endmodule : test_tx_aux_slot_routing
`default_nettype wire

// ---- verilog/tx_aux_slot_routing.sv ----
// Source selection and slot placement for auxiliary transmit channels 5 and 6.
// Assumes a framer that offers each slot as a valid/ready request and a sink
// that drains placed words; all inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module tx_aux_slot_routing
  import tx_aux_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  frame_split,
  input  wire logic                  slot_valid,
  output logic                       slot_ready,
  input  wire logic                  slot_right_half,
  input  wire logic [SLOT_WIDTH-1:0] slot_number,
  input  wire logic [WORD_WIDTH-1:0] loopback_ch1,
  input  wire logic [WORD_WIDTH-1:0] loopback_ch2,
  input  wire logic [WORD_WIDTH-1:0] echo_ref_ch1,
  input  wire logic [WORD_WIDTH-1:0] echo_ref_ch2,
  output logic                       slot_drive,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic      [WORD_WIDTH-1:0] out_word,
  output logic      [SLOT_WIDTH-1:0] out_slot,
  output logic                       out_channel6
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [1:0]            tx_channel5_source_select;
    logic [SLOT_WIDTH-1:0] tx_channel5_slot_position;
    logic [1:0]            tx_channel6_source_select;
    logic [SLOT_WIDTH-1:0] tx_channel6_slot_position;
    logic [7:0]            rdata;
    logic                  drive;
  } routing_state_type;

  localparam routing_state_type RESET_STATE = '{
    tx_channel5_source_select: TX_CH5_ROUTING_RESET[SOURCE_MSB:SOURCE_LSB],
    tx_channel5_slot_position: TX_CH5_ROUTING_RESET[SLOT_MSB:SLOT_LSB],
    tx_channel6_source_select: TX_CH6_ROUTING_RESET[SOURCE_MSB:SOURCE_LSB],
    tx_channel6_slot_position: TX_CH6_ROUTING_RESET[SLOT_MSB:SLOT_LSB],
    rdata:                     UNMAPPED_READ,
    drive:                     1'b0
  };

  routing_state_type      st;
  routing_state_type      next_st;
  logic                   position_ok;
  logic [SLOT_WIDTH-1:0]  position;
  logic                   active5;
  logic                   active6;
  logic                   hit5;
  logic                   hit6;
  logic                   push_valid;
  logic                   push_ready;
  logic [WORD_WIDTH-1:0]  push_word;
  logic [ENTRY_WIDTH-1:0] push_data;
  logic [ENTRY_WIDTH-1:0] pop_data;

  // ********************************************************************
  // Slot matching
  // ********************************************************************
  // Split formats fold left/right halves into 0-15 and 16-31; a split
  // slot above 15 does not exist, so it never matches
  assign position_ok = !frame_split || (slot_number < HALF_FRAME_SLOTS); // RULE3 RULE4
  assign position    = frame_split ? {slot_right_half, slot_number[3:0]} : slot_number; // RULE3 RULE4

  // Only loopback and echo drive; tri-state and reserved stay silent
  assign active5 = (st.tx_channel5_source_select == SRC_LOOPBACK) ||
                   (st.tx_channel5_source_select == SRC_ECHO); // RULE1 RULE8
  assign active6 = (st.tx_channel6_source_select == SRC_LOOPBACK) ||
                   (st.tx_channel6_source_select == SRC_ECHO); // RULE2 RULE8
  assign hit5 = position_ok && active5 && (st.tx_channel5_slot_position == position); // RULE3
  assign hit6 = position_ok && active6 && (st.tx_channel6_slot_position == position); // RULE4

  // Channel 5 wins when both are placed on one slot, so no bus contention
  always_comb
  begin
    if (hit5)
    begin
      push_word = (st.tx_channel5_source_select == SRC_LOOPBACK) ? loopback_ch1
                                                                 : echo_ref_ch1; // RULE1
    end
    else
    begin
      push_word = (st.tx_channel6_source_select == SRC_LOOPBACK) ? loopback_ch2
                                                                 : echo_ref_ch2; // RULE2
    end
  end

  // A silent slot is taken at once; a driven one waits for buffer room
  assign push_valid = slot_valid && (hit5 || hit6);
  assign slot_ready = !(hit5 || hit6) || push_ready;
  assign push_data  = {!hit5, position, push_word};

  // ********************************************************************
  // Output buffer
  // ********************************************************************
  word_buffer #(
    .WIDTH (ENTRY_WIDTH),
    .DEPTH (BUFFER_DEPTH)
  ) buffer_inst (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (pop_data)
  );

  assign out_word     = pop_data[WORD_WIDTH-1:0];
  assign out_slot     = pop_data[WORD_WIDTH+SLOT_WIDTH-1:WORD_WIDTH];
  assign out_channel6 = pop_data[ENTRY_WIDTH-1];
  assign reg_rdata    = st.rdata;
  assign slot_drive   = st.drive;

  // ********************************************************************
  // Register port and next state
  // ********************************************************************
  // Bit 7 is never stored, so it reads zero whatever software writes
  always_comb
  begin
    next_st = st;
    if (reg_write && (reg_addr == TX_CH5_ROUTING_ADDR)) // RULE5
    begin
      next_st.tx_channel5_source_select = reg_wdata[SOURCE_MSB:SOURCE_LSB];
      next_st.tx_channel5_slot_position = reg_wdata[SLOT_MSB:SLOT_LSB];
    end
    if (reg_write && (reg_addr == TX_CH6_ROUTING_ADDR)) // RULE6
    begin
      next_st.tx_channel6_source_select = reg_wdata[SOURCE_MSB:SOURCE_LSB];
      next_st.tx_channel6_slot_position = reg_wdata[SLOT_MSB:SLOT_LSB];
    end
    if (reg_read)
    begin
      case (reg_addr)
        TX_CH5_ROUTING_ADDR: next_st.rdata = {1'b0, st.tx_channel5_source_select,
                                              st.tx_channel5_slot_position}; // RULE7
        TX_CH6_ROUTING_ADDR: next_st.rdata = {1'b0, st.tx_channel6_source_select,
                                              st.tx_channel6_slot_position}; // RULE7
        default:             next_st.rdata = UNMAPPED_READ;
      endcase
    end
    if (slot_valid && slot_ready)
    begin
      next_st.drive = hit5 || hit6; // RULE8
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= RESET_STATE; // RULE5 RULE6
    end
    else
    begin
      st <= next_st;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  ch5_reset_a: assert property (@(posedge clk) $rose(rstn) |->  // RULE5
    {1'b0, st.tx_channel5_source_select, st.tx_channel5_slot_position} == 8'h04)
    else $error("Channel 5 register left reset wrong");

  ch6_reset_a: assert property (@(posedge clk) $rose(rstn) |->  // RULE6
    {1'b0, st.tx_channel6_source_select, st.tx_channel6_slot_position} == 8'h05)
    else $error("Channel 6 register left reset wrong");

  // Write, one idle cycle, then read: the register port's usual spacing
  ch5_readback_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE5
    reg_write && (reg_addr == 8'h22) ##1 !reg_write
    ##1 reg_read && (reg_addr == 8'h22) && !reg_write
    |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 3)})
    else $error("Channel 5 read did not return written value");

  ch6_readback_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE6
    reg_write && (reg_addr == 8'h23) ##1 !reg_write
    ##1 reg_read && (reg_addr == 8'h23) && !reg_write
    |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 3)})
    else $error("Channel 6 read did not return written value");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE7
    reg_rdata[RESERVED_BIT] == 1'b0)
    else $error("Reserved bit read as one");

  ch5_loopback_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE1
    push_valid && hit5 && (st.tx_channel5_source_select == 2'd1) |->
    push_word == loopback_ch1)
    else $error("Channel 5 loopback carried wrong word");

  ch6_echo_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE2
    push_valid && !hit5 && (st.tx_channel6_source_select == 2'd2) |->
    push_word == echo_ref_ch2)
    else $error("Channel 6 echo carried wrong word");

  silent_source_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE8
    (st.tx_channel5_source_select[1] == st.tx_channel5_source_select[0]) &&
    (st.tx_channel6_source_select[1] == st.tx_channel6_source_select[0]) &&
    slot_valid |-> slot_ready && !push_valid ##1 !slot_drive)
    else $error("Tri-stated or reserved channel drove a slot");

  split_slot_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE3
    push_valid && frame_split |-> push_data[ENTRY_WIDTH-2] == slot_right_half)
    else $error("Split slot landed in wrong half");

  ch5_loopback_c: cover property (@(posedge clk) disable iff (!rstn)
    push_valid && push_ready && hit5);
  ch6_echo_c: cover property (@(posedge clk) disable iff (!rstn)
    push_valid && push_ready && hit6 && !hit5);
  reserved_c: cover property (@(posedge clk) disable iff (!rstn)
    slot_valid && (st.tx_channel5_source_select == 2'd3));
  stall_c: cover property (@(posedge clk) disable iff (!rstn)
    slot_valid && !slot_ready);

endmodule : tx_aux_slot_routing

`default_nettype wire

// ---- verilog/word_buffer.sv ----
// Small first-in first-out buffer with valid/ready on both sides.
// Assumes one clock; the drain side may stall for any number of cycles.
`timescale 1ns/1ps
`default_nettype none

module word_buffer
#(
  parameter int WIDTH = 38,
  parameter int DEPTH = 2
)
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PTR = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR-1:0]              rd;
    logic [PTR-1:0]              wr;
    logic [PTR:0]                count;
  } buffer_state_type;

  buffer_state_type st;
  buffer_state_type next_st;
  logic             push;
  logic             pop;

  // Honest flags straight from the occupancy count
  assign in_ready  = (st.count != (PTR+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next state: pointers wrap explicitly so any depth works
  always_comb
  begin
    next_st = st;
    for (int i = 0; i < DEPTH; i++)
    begin
      if (push && (st.wr == PTR'(i)))
      begin
        next_st.mem[i] = in_data;
      end
    end
    if (push)
    begin
      next_st.wr = (st.wr == PTR'(DEPTH-1)) ? '0 : st.wr + PTR'(1);
    end
    if (pop)
    begin
      next_st.rd = (st.rd == PTR'(DEPTH-1)) ? '0 : st.rd + PTR'(1);
    end
    if (push && !pop)
    begin
      next_st.count = st.count + (PTR+1)'(1);
    end
    else if (pop && !push)
    begin
      next_st.count = st.count - (PTR+1)'(1);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  buffer_bound_a: assert property (@(posedge clk) disable iff (!rstn)
    st.count <= (PTR+1)'(DEPTH))
    else $error("Buffer occupancy above depth");

  stall_holds_a: assert property (@(posedge clk) disable iff (!rstn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("Stalled word changed or vanished");

  buffer_full_c: cover property (@(posedge clk) disable iff (!rstn)
    !in_ready && in_valid);

endmodule : word_buffer

`default_nettype wire
